// ==== inc/nv_settings_pkg.sv ====
/*
  Constants and types for the nonvolatile settings and string writer.
  Assumes 64-byte command reports delivered one byte per valid cycle.
*/
`default_nettype none
package nv_settings_pkg;
  // =====================================================================
  // report layout
  localparam int         REPORT_BYTES = 64;
  localparam logic [5:0] IDX_CMD      = 6'h00;
  localparam logic [5:0] IDX_SUB      = 6'h01;
  localparam logic [5:0] IDX_LEN      = 6'h02;
  localparam logic [5:0] IDX_TYPE     = 6'h03;
  localparam logic [5:0] IDX_STR      = 6'h04;
  localparam logic [5:0] IDX_PIN3     = 6'h05;
  localparam logic [5:0] IDX_LAST     = 6'h3F;

  // =====================================================================
  // codes
  localparam logic [7:0] CMD_WRITE_NV     = 8'hB1;
  localparam logic [7:0] SUB_PIN_CFG      = 8'h01;
  localparam logic [7:0] SUB_MFR          = 8'h02;
  localparam logic [7:0] SUB_PROD         = 8'h03;
  localparam logic [7:0] SUB_SERIAL       = 8'h04;
  localparam logic [7:0] DESC_TYPE_STRING = 8'h03;
  localparam logic [7:0] DESC_LEN_MIN     = 8'h02;
  localparam logic [7:0] DESC_LEN_MAX     = 8'h40;

  // =====================================================================
  // pin settings byte fields
  localparam int BIT_LEVEL = 4;
  localparam int BIT_DIR   = 3;
  localparam int FUNC_MSB  = 2;
  localparam logic DIR_INPUT = 1'b1;

  typedef enum logic [2:0] {
    FN_GPIO                   = 3'b000,
    FN_I2C_ACTIVITY_INDICATOR = 3'b001,
    FN_ANALOG_INPUT_THREE     = 3'b010,
    FN_ANALOG_OUTPUT_SECOND   = 3'b011
  } pin_func_t;
  localparam logic [2:0] FUNC_LAST_VALID = 3'b011;

  localparam logic RST_PIN_LEVEL = 1'b0;
  localparam logic RST_PIN_DIR   = 1'b1;

  // =====================================================================
  // string store
  localparam int MAX_CHARS = 31;
  localparam int CHAR_W    = 16;
  localparam int CIDX_W    = 5;

  typedef enum logic [1:0] {
    DESC_MFR    = 2'b00,
    DESC_PROD   = 2'b01,
    DESC_SERIAL = 2'b10,
    DESC_NONE   = 2'b11
  } desc_sel_t;

  typedef enum logic [2:0] {
    ST_IDLE    = 3'b000,
    ST_SUB     = 3'b001,
    ST_PIN     = 3'b010,
    ST_STRHDR  = 3'b011,
    ST_STRDATA = 3'b100,
    ST_SKIP    = 3'b101
  } dec_state_t;
endpackage : nv_settings_pkg
`default_nettype wire

// ==== inc/string_port_if.sv ====
/*
  Carrier between the command decoder and the descriptor string store.
  Assumes both ends on ref_clk.
*/
`timescale 1ns/100ps
`default_nettype none
interface string_port_if;
  import nv_settings_pkg::*;
  logic                  wrEn;
  desc_sel_t             wrSel;
  logic [CIDX_W-1:0]     wrIdx;
  logic [CHAR_W-1:0]     wrChar;
  logic                  lenEn;
  logic [7:0]            lenVal;
  desc_sel_t             rdSel;
  logic [CIDX_W-1:0]     rdIdx;
  logic [CHAR_W-1:0]     rdChar;
  logic [7:0]            rdLen;

  modport writer (output wrEn, wrSel, wrIdx, wrChar, lenEn, lenVal, rdSel, rdIdx,
                  input  rdChar, rdLen);
  modport store  (input  wrEn, wrSel, wrIdx, wrChar, lenEn, lenVal, rdSel, rdIdx,
                  output rdChar, rdLen);
endinterface : string_port_if
`default_nettype wire

// ==== src/string_store.sv ====
/*
  Flip-flop store of the three string descriptors with a registered read port.
  Assumes writes come from the decoder on the same clock.
*/
`timescale 1ns/100ps
`default_nettype none
module string_store #(
  parameter int DEPTH = nv_settings_pkg::MAX_CHARS
) (
  input  wire logic ref_clk,
  input  wire logic rstn,
  string_port_if.store sp
);
  import nv_settings_pkg::*;

  // =====================================================================
  // storage: one row per descriptor
  logic [CHAR_W-1:0] chars [3][DEPTH];
  logic [7:0]        lens_ff [3];
  logic [CHAR_W-1:0] rdChar_ff;
  logic [7:0]        rdLen_ff;

  // character data is not reset; the length bounds what is valid
  always_ff @(posedge ref_clk) begin
    if (sp.wrEn && sp.wrSel != DESC_NONE && int'(sp.wrIdx) < DEPTH) begin
      chars[sp.wrSel][sp.wrIdx] <= sp.wrChar;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      for (int i = 0; i < 3; i++) begin
        lens_ff[i] <= DESC_LEN_MIN;
      end
    end else if (sp.lenEn && sp.wrSel != DESC_NONE) begin
      lens_ff[sp.wrSel] <= sp.lenVal;
    end
  end

  // =====================================================================
  // read port
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      rdChar_ff <= '0;
      rdLen_ff  <= '0;
    end else if (sp.rdSel == DESC_NONE || int'(sp.rdIdx) >= DEPTH) begin
      rdChar_ff <= '0;
      rdLen_ff  <= (sp.rdSel == DESC_NONE) ? 8'h00 : lens_ff[sp.rdSel];
    end else begin
      rdChar_ff <= chars[sp.rdSel][sp.rdIdx];
      rdLen_ff  <= lens_ff[sp.rdSel];
    end
  end

  assign sp.rdChar = rdChar_ff;
  assign sp.rdLen  = rdLen_ff;
endmodule : string_store
`default_nettype wire

// ==== src/flash_settings_string_writer.sv ====
/*
  Decoder of the write-nonvolatile-settings report: power-up setup of
  general_pin_three and the three string descriptors used at enumeration.
  Assumes report bytes arrive on ref_clk logic, one per valid cycle, with
  rptFirst marking byte 0; powerUpApply pulses at power-up/enumeration.
*/
`timescale 1ns/100ps
`default_nettype none
// What this block does
// - After power-up apply, a GPIO output pin drives the stored level from bit 4 of byte 5.
// - Bit 3 of byte 5 gives direction, 1 input and 0 output, and counts only in GPIO mode.
// - Bits 2-0 of byte 5 pick GPIO, I2C activity, analog input three or second analog output; 100-111 are ignored.
// - Sub-command 0x02 stores the characters as the manufacturer string.
// - Sub-command 0x03 stores the characters as the product string.
// - Sub-command 0x04 stores the characters as the serial-number string.
// - Character n is 16 bits, low half at byte 4+2n and high half at byte 4+2n+1.
module flash_settings_string_writer (
  input  wire logic                              ref_clk,
  input  wire logic                              rstn,
  input  wire logic                              rptValid,
  input  wire logic                              rptFirst,
  input  wire logic [7:0]                        rptByte,
  input  wire logic                              powerUpApply,
  input  wire nv_settings_pkg::desc_sel_t        rdSel,
  input  wire logic [nv_settings_pkg::CIDX_W-1:0] rdIdx,
  output logic [nv_settings_pkg::CHAR_W-1:0]     rdChar,
  output logic [7:0]                             rdLen,
  output logic                                   pinThreeOut,
  output logic                                   pinThreeOe,
  output nv_settings_pkg::pin_func_t             pinThreeFunc,
  output logic                                   cmdDone,
  output logic                                   cmdReject
);
  import nv_settings_pkg::*;

  // =====================================================================
  // helpers
  function automatic logic lenOk(input logic [7:0] len);
    return (len >= DESC_LEN_MIN) && (len <= DESC_LEN_MAX) && !len[0];
  endfunction : lenOk

  function automatic logic [6:0] charCount(input logic [7:0] len);
    logic [7:0] body;
    body = len - DESC_LEN_MIN;
    return body[7:1];
  endfunction : charCount

  // =====================================================================
  // byte position
  dec_state_t        state_ff;
  logic [5:0]        cnt_ff;
  logic [5:0]        curIdx;
  logic [5:0]        strOff;
  logic [CIDX_W-1:0] charIdx;
  logic              byteIn;

  assign byteIn  = rptValid;
  assign curIdx  = rptFirst ? IDX_CMD : cnt_ff;
  assign strOff  = curIdx - IDX_STR;
  assign charIdx = strOff[CIDX_W:1];

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      cnt_ff <= IDX_CMD;
    end else if (byteIn) begin
      cnt_ff <= curIdx + 6'h01;
    end
  end

  // =====================================================================
  // decoder state
  desc_sel_t  strSel_ff;
  logic [7:0] len_ff;
  logic [7:0] lowByte_ff;
  logic [7:0] pinPend_ff;
  logic       pinCommit;
  logic       strCommit;
  logic       pinCodeOk;

  assign pinCodeOk = (pinPend_ff[FUNC_MSB:0] <= FUNC_LAST_VALID);
  assign pinCommit = byteIn && !rptFirst && state_ff == ST_PIN && curIdx == IDX_LAST;
  assign strCommit = byteIn && !rptFirst && state_ff == ST_STRDATA && curIdx == IDX_LAST;

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      state_ff <= ST_IDLE;
    end else if (byteIn && rptFirst) begin
      // a new report aborts whatever was in progress
      state_ff <= (rptByte == CMD_WRITE_NV) ? ST_SUB : ST_SKIP;
    end else if (byteIn) begin
      case (state_ff)
        ST_IDLE: begin
          state_ff <= ST_IDLE;
        end
        ST_SUB: begin
          case (rptByte)
            SUB_PIN_CFG: state_ff <= ST_PIN;
            SUB_MFR, SUB_PROD, SUB_SERIAL: state_ff <= ST_STRHDR;
            default: state_ff <= ST_SKIP;
          endcase
        end
        ST_STRHDR: begin
          if (curIdx == IDX_TYPE) begin
            // type and length are checked before any character is written
            state_ff <= (rptByte == DESC_TYPE_STRING && lenOk(len_ff)) ? ST_STRDATA : ST_SKIP;
          end
        end
        ST_PIN, ST_STRDATA, ST_SKIP: begin
          if (curIdx == IDX_LAST) begin
            state_ff <= ST_IDLE;
          end
        end
        default: state_ff <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      strSel_ff <= DESC_NONE;
    end else if (byteIn && state_ff == ST_SUB && !rptFirst) begin
      case (rptByte)
        SUB_MFR:    strSel_ff <= DESC_MFR;
        SUB_PROD:   strSel_ff <= DESC_PROD;
        SUB_SERIAL: strSel_ff <= DESC_SERIAL;
        default:    strSel_ff <= DESC_NONE;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      len_ff     <= DESC_LEN_MIN;
      lowByte_ff <= 8'h00;
      pinPend_ff <= 8'h00;
    end else if (byteIn && !rptFirst) begin
      if (state_ff == ST_STRHDR && curIdx == IDX_LEN) begin
        len_ff <= rptByte;
      end
      if (state_ff == ST_STRDATA && !strOff[0]) begin
        lowByte_ff <= rptByte;
      end
      if (state_ff == ST_PIN && curIdx == IDX_PIN3) begin
        pinPend_ff <= rptByte;
      end
    end
  end

  // =====================================================================
  // string store
  string_port_if sp ();

  // a 64-byte report carries at most 30 characters; the store holds 31
  assign sp.wrEn   = byteIn && !rptFirst && state_ff == ST_STRDATA && strOff[0]
                     && ({2'b00, charIdx} < charCount(len_ff));
  assign sp.wrSel  = strSel_ff;
  assign sp.wrIdx  = charIdx;
  assign sp.wrChar = {rptByte, lowByte_ff};
  assign sp.lenEn  = strCommit;
  assign sp.lenVal = len_ff;
  assign sp.rdSel  = rdSel;
  assign sp.rdIdx  = rdIdx;
  assign rdChar    = sp.rdChar;
  assign rdLen     = sp.rdLen;

  string_store #(.DEPTH(MAX_CHARS)) u_store (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .sp      (sp)
  );

  // =====================================================================
  // stored pin settings and what the pin shows
  logic      nvLevel_ff;
  logic      nvDir_ff;
  pin_func_t nvFunc_ff;
  logic      pinThreeOut_ff;
  logic      pinThreeOe_ff;
  pin_func_t pinThreeFunc_ff;

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      nvLevel_ff <= RST_PIN_LEVEL;
      nvDir_ff   <= RST_PIN_DIR;
      nvFunc_ff  <= FN_GPIO;
    end else if (pinCommit && pinCodeOk) begin
      // an out-of-range function code drops the whole settings byte
      nvLevel_ff <= pinPend_ff[BIT_LEVEL];
      nvDir_ff   <= pinPend_ff[BIT_DIR];
      nvFunc_ff  <= pin_func_t'(pinPend_ff[FUNC_MSB:0]);
    end
  end

  // the pin changes only on apply, never on receipt of a report
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      pinThreeOut_ff  <= RST_PIN_LEVEL;
      pinThreeOe_ff   <= 1'b0;
      pinThreeFunc_ff <= FN_GPIO;
    end else if (powerUpApply) begin
      pinThreeFunc_ff <= nvFunc_ff;
      pinThreeOe_ff   <= (nvFunc_ff == FN_GPIO) && (nvDir_ff != DIR_INPUT);
      pinThreeOut_ff  <= (nvFunc_ff == FN_GPIO) && (nvDir_ff != DIR_INPUT) && nvLevel_ff;
    end
  end

  assign pinThreeOut  = pinThreeOut_ff;
  assign pinThreeOe   = pinThreeOe_ff;
  assign pinThreeFunc = pinThreeFunc_ff;

  // =====================================================================
  // completion strobes
  logic cmdDone_ff;
  logic cmdReject_ff;

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      cmdDone_ff   <= 1'b0;
      cmdReject_ff <= 1'b0;
    end else begin
      cmdDone_ff   <= strCommit || (pinCommit && pinCodeOk);
      cmdReject_ff <= (pinCommit && !pinCodeOk)
                      || (byteIn && !rptFirst && state_ff == ST_SUB
                          && rptByte != SUB_PIN_CFG && rptByte != SUB_MFR
                          && rptByte != SUB_PROD && rptByte != SUB_SERIAL)
                      || (byteIn && !rptFirst && state_ff == ST_STRHDR && curIdx == IDX_TYPE
                          && !(rptByte == DESC_TYPE_STRING && lenOk(len_ff)));
    end
  end

  assign cmdDone   = cmdDone_ff;
  assign cmdReject = cmdReject_ff;

  // =====================================================================
  // checks
  sequence s_sub_byte(logic [7:0] code);
    byteIn && !rptFirst && state_ff == ST_SUB && rptByte == code;
  endsequence

  sequence s_gpio_out_stored;
    nvFunc_ff == FN_GPIO && !nvDir_ff;
  endsequence

  a_pin_level_apply: assert property (@(posedge ref_clk) disable iff (!rstn)
    (s_gpio_out_stored and powerUpApply) |=> pinThreeOe_ff && pinThreeOut_ff == $past(nvLevel_ff))
    else $error("pin level not applied");

  a_dir_gpio_only: assert property (@(posedge ref_clk) disable iff (!rstn)
    pinThreeOe_ff |-> pinThreeFunc_ff == FN_GPIO)
    else $error("pin driven outside GPIO mode");

  a_func_code_ignore: assert property (@(posedge ref_clk) disable iff (!rstn)
    (pinCommit && pinPend_ff[FUNC_MSB:0] > FUNC_LAST_VALID)
      |=> $stable(nvFunc_ff) && $stable(nvLevel_ff) && $stable(nvDir_ff) && !cmdDone_ff && cmdReject_ff)
    else $error("reserved function code taken");

  a_cmd_code_gate: assert property (@(posedge ref_clk) disable iff (!rstn)
    (byteIn && rptFirst && rptByte != CMD_WRITE_NV) |=> state_ff == ST_SKIP)
    else $error("foreign command decoded");

  a_mfr_route: assert property (@(posedge ref_clk) disable iff (!rstn)
    s_sub_byte(SUB_MFR) |=> strSel_ff == DESC_MFR && state_ff == ST_STRHDR)
    else $error("manufacturer string misrouted");

  a_prod_route: assert property (@(posedge ref_clk) disable iff (!rstn)
    s_sub_byte(SUB_PROD) |=> strSel_ff == DESC_PROD && state_ff == ST_STRHDR)
    else $error("product string misrouted");

  a_serial_route: assert property (@(posedge ref_clk) disable iff (!rstn)
    s_sub_byte(SUB_SERIAL) |=> strSel_ff == DESC_SERIAL && state_ff == ST_STRHDR)
    else $error("serial string misrouted");

  a_char_pairing: assert property (@(posedge ref_clk) disable iff (!rstn)
    sp.wrEn |-> sp.wrChar[15:8] == rptByte && curIdx == IDX_STR + {sp.wrIdx, 1'b1} && sp.wrSel != DESC_NONE)
    else $error("character halves misplaced");

  a_no_early_apply: assert property (@(posedge ref_clk) disable iff (!rstn)
    !powerUpApply |=> $stable(pinThreeOut_ff) && $stable(pinThreeOe_ff) && $stable(pinThreeFunc_ff))
    else $error("pin changed without apply");
endmodule : flash_settings_string_writer
`default_nettype wire

// ==== tb/report_host.sv ====
/*
  Host model: builds 64-byte settings reports and sends them one byte per clock, or one every two clocks in slow mode
  Assumes the writer samples on the rising edge of ref_clk.
*/
`timescale 1ns/100ps
`default_nettype none
module report_host (
  input  wire logic       ref_clk,
  output logic            rptValid,
  output logic            rptFirst,
  output logic [7:0]      rptByte
);
  logic [7:0] rpt [64];

  initial begin
    rptValid = 1'b0;
    rptFirst = 1'b0;
    rptByte  = 8'h5A;
  end

  // ====================
  // report builders
  task automatic build_str(input logic [7:0] sub, input int nch, input logic [7:0] base);
    rpt = '{default: 8'h00};
    rpt[0] = 8'hB1;
    rpt[1] = sub;
    rpt[2] = 8'(2 + 2 * nch);
    rpt[3] = 8'h03;
    for (int n = 0; n < nch; n++) begin
      rpt[4 + 2 * n]     = base ^ 8'(n);
      rpt[4 + 2 * n + 1] = 8'(n) + 8'h30;
    end
  endtask : build_str

  task automatic build_pin(input logic [7:0] cfg);
    rpt = '{default: 8'h00};
    rpt[0] = 8'hB1;
    rpt[1] = 8'h01;
    rpt[5] = cfg;
  endtask : build_pin

  // ====================
  // sender; idle bytes carry the inverse so a stale value never matches
  task automatic send(input int nbytes, input bit slow);
    for (int i = 0; i < nbytes; i++) begin
      @(negedge ref_clk);
      rptValid = 1'b1;
      rptFirst = (i == 0);
      rptByte  = rpt[i];
      if (slow) begin
        @(negedge ref_clk);
        rptValid = 1'b0;
        rptFirst = 1'b0;
        rptByte  = ~rpt[i];
      end
    end
    @(negedge ref_clk);
    rptValid = 1'b0;
    rptFirst = 1'b0;
    rptByte  = ~rpt[nbytes - 1];
  endtask : send
endmodule : report_host
`default_nettype wire

// ==== tb/flash_settings_string_writer_bench.sv ====
/*
  Self-checking bench for the settings and string writer.
  Assumes the host model drives the report bus at the falling edge.
*/
`timescale 1ns/100ps
`default_nettype none
module flash_settings_string_writer_bench;
  import nv_settings_pkg::*;
  logic              ref_clk;
  logic              rstn;
  logic              rptValid;
  logic              rptFirst;
  logic [7:0]        rptByte;
  logic              powerUpApply;
  desc_sel_t         rdSel;
  logic [CIDX_W-1:0] rdIdx;
  logic [CHAR_W-1:0] rdChar;
  logic [7:0]        rdLen;
  logic              pinThreeOut;
  logic              pinThreeOe;
  pin_func_t         pinThreeFunc;
  logic              cmdDone;
  logic              cmdReject;
  int                nFail;
  int                nTests;
  int                doneCnt;
  int                rejCnt;

  flash_settings_string_writer flash_settings_string_writer_inst (
    .ref_clk(ref_clk), .rstn(rstn), .rptValid(rptValid), .rptFirst(rptFirst),
    .rptByte(rptByte), .powerUpApply(powerUpApply), .rdSel(rdSel), .rdIdx(rdIdx),
    .rdChar(rdChar), .rdLen(rdLen), .pinThreeOut(pinThreeOut), .pinThreeOe(pinThreeOe),
    .pinThreeFunc(pinThreeFunc), .cmdDone(cmdDone), .cmdReject(cmdReject));

  report_host report_host_inst (
    .ref_clk(ref_clk), .rptValid(rptValid), .rptFirst(rptFirst), .rptByte(rptByte));

  always #5 ref_clk = ~ref_clk;

  always @(posedge ref_clk) begin
    if (cmdDone === 1'b1) doneCnt++;
    if (cmdReject === 1'b1) rejCnt++;
  end

  // ====================
  // helpers
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    nTests++;
    if (got !== exp) begin
      nFail++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // answer lands one cycle after byte 63, so two falling edges suffice
  task automatic run(input int nbytes, input bit slow, input int expDone, input int expRej);
    doneCnt = 0;
    rejCnt  = 0;
    report_host_inst.send(nbytes, slow);
    repeat (2) @(negedge ref_clk);
    chk(16'(doneCnt), 16'(expDone));
    chk(16'(rejCnt), 16'(expRej));
  endtask : run

  task automatic apply_pin(input logic out, input logic oe, input logic [2:0] fn);
    @(negedge ref_clk);
    powerUpApply = 1'b1;
    @(negedge ref_clk);
    powerUpApply = 1'b0;
    chk({13'h0, fn}, {13'h0, pinThreeFunc});
    chk({14'h0, out, oe}, {14'h0, pinThreeOut, pinThreeOe});
  endtask : apply_pin

  task automatic rd(input logic [1:0] sel, input int idx, input logic [15:0] expC, input logic [7:0] expL);
    rdSel = desc_sel_t'(sel);
    rdIdx = 5'(idx);
    @(negedge ref_clk);
    chk(rdChar, expC);
    chk({8'h00, rdLen}, {8'h00, expL});
  endtask : rd

  function automatic logic [15:0] ch(input logic [7:0] base, input int n);
    return {8'(n) + 8'h30, base ^ 8'(n)};
  endfunction : ch

  // ====================
  // scenarios
  task automatic t_reset();
    chk({9'h0, pinThreeFunc, pinThreeOut, pinThreeOe, cmdDone, cmdReject}, 16'h0000);
    // character rows are not reset, so only the out-of-range slot reads as zero
    for (int s = 0; s < 3; s++) rd(2'(s), 31, 16'h0000, 8'h02);
    rd(2'b11, 0, 16'h0000, 8'h00);
  endtask : t_reset

  task automatic t_pin();
    report_host_inst.build_pin(8'hF0);
    run(64, 1'b0, 1, 0);
    chk({14'h0, pinThreeOut, pinThreeOe}, 16'h0000);
    apply_pin(1'b1, 1'b1, 3'b000);
    report_host_inst.build_pin(8'h18);
    run(64, 1'b1, 1, 0);
    apply_pin(1'b0, 1'b0, 3'b000);
    for (int f = 1; f < 4; f++) begin
      report_host_inst.build_pin(8'h10 | 8'(f));
      run(64, 1'b0, 1, 0);
      apply_pin(1'b0, 1'b0, 3'(f));
    end
    report_host_inst.build_pin(8'h14);
    run(64, 1'b0, 0, 1);
    apply_pin(1'b0, 1'b0, 3'b011);
  endtask : t_pin

  task automatic t_str();
    int nch [3] = '{30, 1, 7};
    for (int s = 0; s < 3; s++) begin
      report_host_inst.build_str(8'(2 + s), nch[s], 8'h41 + 8'(s));
      run(64, s == 1, 1, 0);
      for (int n = 0; n < nch[s]; n++) rd(2'(s), n, ch(8'h41 + 8'(s), n), 8'(2 + 2 * nch[s]));
      rd(2'(s), 31, 16'h0000, 8'(2 + 2 * nch[s]));
    end
  endtask : t_str

  task automatic t_bad();
    report_host_inst.build_str(8'h02, 3, 8'h70);
    report_host_inst.rpt[0] = 8'hB0;
    run(64, 1'b0, 0, 0);
    rd(2'b00, 0, ch(8'h41, 0), 8'h3E);
    report_host_inst.rpt[0] = 8'hB1;
    report_host_inst.rpt[1] = 8'h05;
    run(64, 1'b0, 0, 1);
    report_host_inst.rpt[1] = 8'h02;
    report_host_inst.rpt[3] = 8'h04;
    run(64, 1'b0, 0, 1);
    report_host_inst.rpt[3] = 8'h03;
    report_host_inst.rpt[2] = 8'h07;
    run(64, 1'b0, 0, 1);
    rd(2'b00, 0, ch(8'h41, 0), 8'h3E);
    report_host_inst.rpt[2] = 8'h08;
    run(10, 1'b0, 0, 0);
    report_host_inst.rpt[0] = 8'hB0;
    run(64, 1'b0, 0, 0);
    rd(2'b00, 2, ch(8'h70, 2), 8'h3E);
    rd(2'b00, 3, ch(8'h41, 3), 8'h3E);
  endtask : t_bad

  // ====================
  // run control
  task automatic conclude();
    $display("tests %0d failures %0d", nTests, nFail);
    if (nFail == 0 && nTests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : conclude

  initial begin
    #300000;
    nFail++;
    conclude();
  end

  initial begin
    ref_clk      = 1'b0;
    rstn         = 1'b0;
    powerUpApply = 1'b0;
    rdSel        = DESC_NONE;
    rdIdx        = 5'h00;
    nFail        = 0;
    nTests       = 0;
    repeat (20) @(negedge ref_clk);
    rstn = 1'b1;
    @(negedge ref_clk);
    t_reset();
    t_pin();
    t_str();
    t_bad();
    conclude();
  end
endmodule : flash_settings_string_writer_bench
`default_nettype wire
